// [rtl/dcp_device.sv]
`timescale 1ns/1ns
module dcp_device (
    input  wire logic        clk,
    input  wire logic        srst,
    dcp_if.dev               link,
    input  wire logic [23:0] cpu_pc,
    input  wire logic [7:0]  cpu_flags,
    input  wire logic [31:0] cpu_reg_rdata,
    output logic             onchip_debugger_active,
    output logic             pc_wr,
    output logic [23:0]      pc_wdata,
    output logic             instr_valid,
    output logic [15:0]      instr_word,
    output logic [3:0]       reg_sel,
    output logic             reg_wr,
    output logic [31:0]      reg_wdata
);
    import dcp_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        DP_CMD,
        DP_RX,
        DP_TX,
        DP_CRC
    } dcp_dphase_t;

    typedef struct packed {
        dcp_eng_t    eng;
        dcp_dphase_t phase;
        logic        inited;
        logic        skip_crc;
        logic        load_reg;
        logic [7:0]  cmd;
        logic [2:0]  nleft;
        logic [31:0] buf_w;
        logic [7:0]  crc;
        logic        pc_wr;
        logic [23:0] pc_wdata;
        logic        instr_valid;
        logic [15:0] instr_word;
        logic [3:0]  reg_sel;
        logic        reg_wr;
        logic [31:0] reg_wdata;
    } dcp_dstate_t;

    dcp_dstate_t s;
    dcp_dstate_t next_s;
    logic        done;
    logic        idle;
    logic [7:0]  b;
    dcp_shape_t  shp;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s             = s;
        done               = dcp_eng_done(s.eng);
        idle               = !s.eng.busy && !s.eng.wait_edge;
        b                  = s.eng.sh;
        shp                = dcp_shape(s.eng.sh);
        next_s.eng         = dcp_eng_step(s.eng, link.debug_serial_pin);
        next_s.pc_wr       = 1'b0;
        next_s.instr_valid = 1'b0;
        next_s.reg_wr      = 1'b0;
        unique case (s.phase)
            DP_CMD: begin
                if (idle) begin
                    next_s.eng = dcp_eng_rx(next_s.eng);
                end
                // A refused or unknown byte leaves the phase as it is.
                if (done && s.eng.ack && (s.inited || b == CMD_REV) && shp.known) begin
                    next_s.cmd      = b;
                    next_s.crc      = dcp_crc8(CRC_INIT, b);
                    next_s.phase    = (shp.n_out != NB_0) ? DP_RX : DP_TX;
                    next_s.nleft    = (shp.n_out != NB_0) ? shp.n_out : shp.n_in;
                    next_s.skip_crc = 1'b0;
                    if (b == CMD_REV) begin
                        next_s.inited   = 1'b1;
                        next_s.skip_crc = !s.inited;
                        next_s.buf_w    = {REVISION, 16'h0000};
                    end else if (b == CMD_RD_PC) begin
                        next_s.buf_w = {ZERO_BYTE, cpu_pc};
                    end else if (b == CMD_RD_FLAGS) begin
                        next_s.buf_w = {ZERO_BYTE, cpu_flags, 16'h0000};
                    end
                    if (b[7:4] == NIB_RD_REG || b[7:4] == NIB_WR_REG) begin
                        next_s.reg_sel = b[3:0];
                    end
                    // The register file answers one cycle after the selector moves.
                    next_s.load_reg = (b[7:4] == NIB_RD_REG);
                end
            end
            DP_RX: begin
                if (idle) begin
                    next_s.eng = dcp_eng_rx(next_s.eng);
                end
                if (done && s.eng.ack) begin
                    next_s.crc   = dcp_crc8(s.crc, b);
                    next_s.buf_w = {s.buf_w[23:0], b};
                    next_s.nleft = s.nleft - NB_1;
                    if (s.nleft == NB_1) begin
                        next_s.phase = DP_CRC;
                        if (s.cmd == CMD_WR_PC) begin
                            next_s.pc_wr    = 1'b1;
                            next_s.pc_wdata = {s.buf_w[15:0], b};
                        end else if (s.cmd == CMD_WR_INSTR) begin
                            next_s.instr_valid = 1'b1;
                            next_s.instr_word  = {s.buf_w[7:0], b};
                        end else begin
                            next_s.reg_wr    = 1'b1;
                            next_s.reg_wdata = {s.buf_w[23:0], b};
                        end
                    end
                end
            end
            DP_TX: begin
                if (s.load_reg) begin
                    next_s.buf_w    = cpu_reg_rdata;
                    next_s.load_reg = 1'b0;
                end else if (idle) begin
                    next_s.eng = dcp_eng_tx(next_s.eng, s.buf_w[31:24]);
                end
                if (done) begin
                    next_s.crc   = dcp_crc8(s.crc, s.buf_w[31:24]);
                    next_s.buf_w = {s.buf_w[23:0], ZERO_BYTE};
                    next_s.nleft = s.nleft - NB_1;
                    if (s.nleft == NB_1) begin
                        next_s.phase = s.skip_crc ? DP_CMD : DP_CRC;
                    end
                end
            end
            DP_CRC: begin
                if (idle) begin
                    next_s.eng = dcp_eng_tx(next_s.eng, dcp_bitrev(s.crc));
                end
                if (done) begin
                    next_s.phase = DP_CMD;
                end
            end
        endcase
        next_s.eng.oe_n = dcp_eng_oe_n(next_s.eng);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            s              <= '0;
            s.eng.oe_n     <= 1'b1;
            s.eng.line_q   <= 1'b1;
            s.crc          <= CRC_INIT;
        end else begin
            s <= next_s;
        end
    end

    assign link.dev_drv           = 1'b0;
    assign link.dev_oe_n          = s.eng.oe_n;
    assign onchip_debugger_active = s.inited;
    assign pc_wr                  = s.pc_wr;
    assign pc_wdata               = s.pc_wdata;
    assign instr_valid            = s.instr_valid;
    assign instr_word             = s.instr_word;
    assign reg_sel                = s.reg_sel;
    assign reg_wr                 = s.reg_wr;
    assign reg_wdata              = s.reg_wdata;

endmodule // dcp_device

// [rtl/dcp_host.sv]
`timescale 1ns/1ns
module dcp_host (
    input  wire logic        clk,
    input  wire logic        srst,
    dcp_if.host              link,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [31:0] cmd_wdata,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic             rsp_ok,
    output logic [31:0]      rsp_data
);
    import dcp_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {
        HP_IDLE,
        HP_CMD,
        HP_OUT,
        HP_IN,
        HP_CRC
    } dcp_hphase_t;

    typedef struct packed {
        dcp_eng_t    eng;
        dcp_hphase_t phase;
        logic        rev_seen;
        logic        skip_crc;
        logic [7:0]  cmd;
        logic [2:0]  nout;
        logic [2:0]  nin;
        logic [31:0] buf_w;
        logic [7:0]  crc;
        logic        cmd_ready;
        logic        rsp_valid;
        logic        rsp_ok;
        logic [31:0] rsp_data;
    } dcp_hstate_t;

    dcp_hstate_t s;
    dcp_hstate_t next_s;
    logic        done;
    logic        idle;
    dcp_shape_t  shp;

    always_comb begin
        next_s           = s;
        done             = dcp_eng_done(s.eng);
        idle             = !s.eng.busy && !s.eng.wait_edge;
        shp              = dcp_shape(cmd_code);
        next_s.eng       = dcp_eng_step(s.eng, link.debug_serial_pin);
        next_s.rsp_valid = 1'b0;
        unique case (s.phase)
            HP_IDLE: begin
                if (cmd_valid && s.cmd_ready) begin
                    next_s.cmd      = cmd_code;
                    next_s.nout     = shp.n_out;
                    next_s.nin      = shp.n_in;
                    next_s.rsp_data = '0;
                    next_s.buf_w    = (shp.n_out == NB_2) ? {cmd_wdata[15:0], 16'h0000} : cmd_wdata;
                    next_s.skip_crc = (cmd_code == CMD_REV) && !s.rev_seen;
                    next_s.rev_seen = s.rev_seen || (cmd_code == CMD_REV);
                    if (shp.known) begin
                        next_s.phase = HP_CMD;
                    end else begin
                        // The far end would stay silent, so an unknown code is refused here.
                        next_s.rsp_valid = 1'b1;
                        next_s.rsp_ok    = 1'b0;
                    end
                end
            end
            HP_CMD: begin
                if (idle) begin
                    next_s.eng = dcp_eng_tx(next_s.eng, s.cmd);
                end
                if (done) begin
                    next_s.crc   = dcp_crc8(CRC_INIT, s.cmd);
                    next_s.phase = (s.nout != NB_0) ? HP_OUT : HP_IN;
                end
            end
            HP_OUT: begin
                if (idle) begin
                    next_s.eng = dcp_eng_tx(next_s.eng, s.buf_w[31:24]);
                end
                if (done) begin
                    next_s.crc   = dcp_crc8(s.crc, s.buf_w[31:24]);
                    next_s.buf_w = {s.buf_w[23:0], ZERO_BYTE};
                    next_s.nout  = s.nout - NB_1;
                    if (s.nout == NB_1) begin
                        next_s.phase = HP_CRC;
                    end
                end
            end
            HP_IN: begin
                if (idle) begin
                    next_s.eng = dcp_eng_rx(next_s.eng);
                end
                // A byte without the zero acknowledge is a silent far end; poll again.
                if (done && s.eng.ack) begin
                    next_s.crc      = dcp_crc8(s.crc, s.eng.sh);
                    next_s.rsp_data = {s.rsp_data[23:0], s.eng.sh};
                    next_s.nin      = s.nin - NB_1;
                    if (s.nin == NB_1) begin
                        next_s.phase = s.skip_crc ? HP_IDLE : HP_CRC;
                        next_s.rsp_valid = s.skip_crc;
                        next_s.rsp_ok    = 1'b1;
                    end
                end
            end
            HP_CRC: begin
                if (idle) begin
                    next_s.eng = dcp_eng_rx(next_s.eng);
                end
                if (done && s.eng.ack) begin
                    next_s.phase     = HP_IDLE;
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_ok    = (s.eng.sh == dcp_bitrev(s.crc));
                end
            end
            default: begin
                next_s.phase = HP_IDLE;
            end
        endcase
        next_s.cmd_ready = (next_s.phase == HP_IDLE) && !(s.phase == HP_IDLE && cmd_valid && s.cmd_ready);
        next_s.eng.oe_n  = dcp_eng_oe_n(next_s.eng);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s            <= '0;
            s.eng.oe_n   <= 1'b1;
            s.eng.line_q <= 1'b1;
            s.crc        <= CRC_INIT;
        end else begin
            s <= next_s;
        end
    end

    assign link.host_drv  = 1'b0;
    assign link.host_oe_n = s.eng.oe_n;
    assign cmd_ready      = s.cmd_ready;
    assign rsp_valid      = s.rsp_valid;
    assign rsp_ok         = s.rsp_ok;
    assign rsp_data       = s.rsp_data;

endmodule // dcp_host

// [rtl/dcp_if.sv]
`timescale 1ns/1ns
interface dcp_if;
    logic debug_serial_pin;
    logic dev_drv;
    logic dev_oe_n;
    logic host_drv;
    logic host_oe_n;

    // ************************************************************
    // Wired line with pull-up
    // ************************************************************
    assign debug_serial_pin = (dev_oe_n | dev_drv) & (host_oe_n | host_drv);

    modport dev (output dev_drv, output dev_oe_n, input debug_serial_pin);
    modport host (output host_drv, output host_oe_n, input debug_serial_pin);
endinterface

// [rtl/dcp_pkg.sv]
// Behaviour
// - Drop all bytes until read-revision command arrives.
// - First read-revision reply carries no CRC byte.
// - Receiver sends start bit; transmitter then sends.
// - Host receives by sending an all-ones character.
// - Parity bit is zero, used as acknowledge.
// - Read PC returns zero, PC MSB first, CRC.
// - Write PC takes zero, three bytes; CRC reply.
// - Read flags returns zero, flags, then CRC.
// - Write instruction takes opcode high, low; CRC.
// - Read register returns four bytes, then CRC.
// - Write register takes four bytes; CRC reply.
package dcp_pkg;

    // ************************************************************
    // Serial timing
    // ************************************************************
    localparam int unsigned CLK_HZ     = 50_000_000;
    // A fast debug line keeps a full command packet to a few thousand clocks.
    localparam int unsigned BAUD_HZ    = 1_000_000;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam int unsigned CNT_W      = 10;
    localparam int unsigned SLOT_W     = 4;
    localparam logic [CNT_W-1:0]  BIT_LAST  = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0]  BIT_HALF  = CNT_W'(BIT_CYCLES / 2);
    localparam logic [CNT_W-1:0]  CNT_ONE   = 10'h001;
    localparam logic [SLOT_W-1:0] SLOT_START = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_D0    = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_D7    = 4'h8;
    localparam logic [SLOT_W-1:0] SLOT_PAR   = 4'h9;
    localparam logic [SLOT_W-1:0] SLOT_STOP  = 4'ha;
    localparam logic [SLOT_W-1:0] SLOT_STEP  = 4'h1;

    // ************************************************************
    // Commands and packet layout
    // ************************************************************
    localparam logic [7:0]  CMD_REV      = 8'h00;
    localparam logic [7:0]  CMD_RD_PC    = 8'h06;
    localparam logic [7:0]  CMD_WR_PC    = 8'h07;
    localparam logic [7:0]  CMD_RD_FLAGS = 8'h08;
    localparam logic [7:0]  CMD_WR_INSTR = 8'h09;
    localparam logic [3:0]  NIB_RD_REG   = 4'h4;
    localparam logic [3:0]  NIB_WR_REG   = 4'h5;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    localparam logic [2:0]  NB_0         = 3'h0;
    localparam logic [2:0]  NB_1         = 3'h1;
    localparam logic [2:0]  NB_2         = 3'h2;
    localparam logic [2:0]  NB_4         = 3'h4;
    localparam logic [7:0]  CRC_POLY     = 8'h07;
    localparam logic [7:0]  CRC_INIT     = 8'hff;
    // Revision code is arbitrary.
    localparam logic [15:0] REVISION     = 16'h0a5c;

    typedef struct packed {
        logic             known;
        logic [2:0]       n_out;
        logic [2:0]       n_in;
    } dcp_shape_t;

    typedef struct packed {
        logic              busy;
        logic              wait_edge;
        logic              tx_role;
        logic [SLOT_W-1:0] slot;
        logic [CNT_W-1:0]  cnt;
        logic [7:0]        sh;
        logic              ack;
        logic              line_q;
        logic              oe_n;
    } dcp_eng_t;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic dcp_shape_t dcp_shape(logic [7:0] c);
        dcp_shape_t r;
        r = '{known: 1'b1, n_out: NB_0, n_in: NB_0};
        if (c == CMD_REV) begin
            r.n_in = NB_2;
        end else if (c == CMD_RD_PC) begin
            r.n_in = NB_4;
        end else if (c == CMD_WR_PC) begin
            r.n_out = NB_4;
        end else if (c == CMD_RD_FLAGS) begin
            r.n_in = NB_2;
        end else if (c == CMD_WR_INSTR) begin
            r.n_out = NB_2;
        end else if (c[7:4] == NIB_RD_REG) begin
            r.n_in = NB_4;
        end else if (c[7:4] == NIB_WR_REG) begin
            r.n_out = NB_4;
        end else begin
            r.known = 1'b0;
        end
        return r;
    endfunction

    function automatic logic [7:0] dcp_crc8(logic [7:0] crc, logic [7:0] d);
        logic [7:0] r;
        r = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] dcp_bitrev(logic [7:0] d);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction

    function automatic dcp_eng_t dcp_eng_rx(dcp_eng_t e);
        dcp_eng_t r;
        r         = e;
        r.busy    = 1'b1;
        r.tx_role = 1'b0;
        r.slot    = SLOT_START;
        r.cnt     = '0;
        r.ack     = 1'b0;
        return r;
    endfunction

    function automatic dcp_eng_t dcp_eng_tx(dcp_eng_t e, logic [7:0] d);
        dcp_eng_t r;
        r           = e;
        r.tx_role   = 1'b1;
        r.wait_edge = 1'b1;
        r.sh        = d;
        return r;
    endfunction

    function automatic logic dcp_eng_done(dcp_eng_t e);
        return e.busy && e.cnt == BIT_LAST && e.slot == SLOT_STOP;
    endfunction

    // One clock step of the frame engine; line is the wired-AND level.
    function automatic dcp_eng_t dcp_eng_step(dcp_eng_t e, logic line);
        dcp_eng_t r;
        r        = e;
        r.line_q = line;
        if (e.busy) begin
            if (e.cnt == BIT_LAST) begin
                r.cnt = '0;
                if (e.slot == SLOT_STOP) begin
                    r.busy = 1'b0;
                end else begin
                    r.slot = e.slot + SLOT_STEP;
                end
            end else begin
                r.cnt = e.cnt + CNT_ONE;
            end
            if (!e.tx_role && e.cnt == BIT_HALF) begin
                if (e.slot >= SLOT_D0 && e.slot <= SLOT_D7) begin
                    r.sh = {line, e.sh[7:1]};
                end
                if (e.slot == SLOT_PAR) begin
                    r.ack = ~line;
                end
            end
        end else if (e.wait_edge && e.line_q && !line) begin
            r.wait_edge = 1'b0;
            r.busy      = 1'b1;
            r.slot      = SLOT_START;
            r.cnt       = CNT_ONE;
        end
        return r;
    endfunction

    // Open drain: only zeros are driven, ones are left to the pull-up.
    function automatic logic dcp_eng_oe_n(dcp_eng_t e);
        logic low;
        low = 1'b0;
        if (e.busy && !e.tx_role) begin
            low = (e.slot == SLOT_START);
        end else if (e.busy) begin
            if (e.slot >= SLOT_D0 && e.slot <= SLOT_D7) begin
                low = !e.sh[3'(e.slot - SLOT_STEP)];
            end
            low = low || (e.slot == SLOT_PAR);
        end
        return !low;
    endfunction

endpackage

// [tb/dcp_asserts.sv]
`timescale 1ns/1ns
// ****************************************
// Wire checks on the shared debug line
// ****************************************
module dcp_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic debug_serial_pin,
    input wire logic dev_drv,
    input wire logic dev_oe_n,
    input wire logic host_drv,
    input wire logic host_oe_n
);
    import dcp_pkg::*;
    logic [15:0] dev_run;
    logic [15:0] host_run;

    // Low runs are counted so slot lengths can be judged without long repetitions.
    always_ff @(posedge clk) begin
        dev_run  <= (srst || dev_oe_n) ? 16'h0000 : dev_run + 16'h0001;
        host_run <= (srst || host_oe_n) ? 16'h0000 : host_run + 16'h0001;
    end

    AST_DEV_IN_RESET: assert property (@(posedge clk) srst |=> dev_oe_n)
        else $error("device pulls the line in reset");
    AST_HOST_IN_RESET: assert property (@(posedge clk) srst |=> host_oe_n)
        else $error("host pulls the line in reset");
    AST_HOST_QUIET: assert property (@(posedge clk) disable iff (srst) $fell(srst) |-> host_oe_n [*2])
        else $error("host pulls the line right after reset");
    AST_DEV_POLL: assert property (@(posedge clk) disable iff (srst) $fell(srst) |-> ##[1:3] !dev_oe_n)
        else $error("device sends no start bit after reset");
    AST_DEV_SLOTS: assert property (@(posedge clk) disable iff (srst)
        $rose(dev_oe_n) && !$past(srst) |-> dev_run != 16'h0000 && dev_run % BIT_CYCLES == 0)
        else $error("device low run is not whole bit slots");
    AST_HOST_SLOTS: assert property (@(posedge clk) disable iff (srst)
        $rose(host_oe_n) && !$past(srst) |-> host_run != 16'h0000 && host_run % BIT_CYCLES == 0)
        else $error("host low run is not whole bit slots");
    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (srst) dev_drv == 1'b0 && host_drv == 1'b0)
        else $error("an end drives a high level");
    AST_ONE_DRIVER: assert property (@(posedge clk) disable iff (srst) dev_oe_n || host_oe_n)
        else $error("both ends pull the line");

    cover property (@(posedge clk) $rose(dev_oe_n) && dev_run == 16'(BIT_CYCLES));
    cover property (@(posedge clk) $rose(host_oe_n) && host_run > 16'(BIT_CYCLES));
    cover property (@(posedge clk) $fell(host_oe_n) && $past(debug_serial_pin));
endmodule // dcp_asserts

// [tb/debug_command_port_test.sv]
`timescale 1ns/1ns
module debug_command_port_test;
    import dcp_pkg::*;
    logic        clk       = 1'b0;
    logic        srst      = 1'b1;
    logic        cmd_valid = 1'b0;
    logic [7:0]  cmd_code  = 8'h00;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic [23:0] cpu_pc    = 24'h5a3c81;
    logic [7:0]  cpu_flags = 8'hc6;
    logic [31:0] cpu_reg_rdata;
    logic        active, pc_wr, instr_valid, reg_wr, cmd_ready, rsp_valid, rsp_ok;
    logic [23:0] pc_wdata;
    logic [15:0] instr_word;
    logic [3:0]  reg_sel;
    logic [31:0] reg_wdata, rsp_data;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          n_instr     = 0;
    int          n_wr        = 0;

    always #10 clk = ~clk;

    dcp_if link_if();
    dcp_device i_dcp_device (.clk(clk), .srst(srst), .link(link_if), .cpu_pc(cpu_pc), .cpu_flags(cpu_flags),
        .cpu_reg_rdata(cpu_reg_rdata), .onchip_debugger_active(active), .pc_wr(pc_wr), .pc_wdata(pc_wdata),
        .instr_valid(instr_valid), .instr_word(instr_word), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata));
    dcp_host i_dcp_host (.clk(clk), .srst(srst), .link(link_if), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
        .rsp_data(rsp_data));
    dcp_asserts i_dcp_asserts (.clk(clk), .srst(srst), .debug_serial_pin(link_if.debug_serial_pin),
        .dev_drv(link_if.dev_drv), .dev_oe_n(link_if.dev_oe_n), .host_drv(link_if.host_drv),
        .host_oe_n(link_if.host_oe_n));

    // The register file answer depends on the selector, so a wrong selector shows in the data.
    assign cpu_reg_rdata = {28'h9e1b47d, reg_sel};

    always @(posedge clk) begin
        if (instr_valid === 1'b1) n_instr++;
        if (pc_wr === 1'b1 || reg_wr === 1'b1) n_wr++;
    end

    task automatic wrap_up;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Bounded wait on a completion flag, sampled after the edge has settled.
    task automatic wait_flag(ref logic flag, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) begin
                check(33'h0, 33'h1, "timeout");
                wrap_up();
            end
        end while (flag !== 1'b1);
    endtask

    task automatic do_cmd(input logic [7:0] code, input logic [31:0] wd, output logic [32:0] rsp);
        wait_flag(cmd_ready, 100);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_wdata <= wd;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        if (rsp_valid !== 1'b1) begin
            wait_flag(rsp_valid, 40000);
        end
        rsp = {rsp_ok, rsp_data};
    endtask

    initial begin
        logic [32:0] r;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check({32'h0, active}, 33'h0, "debugger active too early");
        do_cmd(CMD_REV, 32'h0, r);
        check(r, {1'b1, 16'h0000, REVISION}, "revision reply");
        check({32'h0, active}, 33'h1, "debugger not active");
        do_cmd(CMD_RD_FLAGS, 32'h0, r);
        check(r, {1'b1, 24'h000000, cpu_flags}, "flags reply");
        do_cmd(CMD_WR_INSTR, 32'h0000be2d, r);
        check({r[32], instr_word, 16'h0000}, {1'b1, 16'hbe2d, 16'h0000}, "opcode word");
        check(33'(n_instr * 2 + n_wr), 33'h2, "cpu strobes");
        do_cmd({NIB_RD_REG, 4'hb}, 32'h0, r);
        check(r, {1'b1, 28'h9e1b47d, 4'hb}, "register reply");
        check({29'h0, reg_sel}, 33'hb, "register selector");
        do_cmd(CMD_RD_PC, 32'h0, r);
        check(r, {1'b1, 8'h00, cpu_pc}, "program counter reply");
        do_cmd(CMD_WR_PC, 32'h0013_579b, r);
        check({r[32], 8'h00, pc_wdata}, {1'b1, 32'h0013_579b}, "program counter write");
        do_cmd({NIB_WR_REG, 4'h3}, 32'hc0de_4a71, r);
        check({r[32], reg_wdata}, {1'b1, 32'hc0de_4a71}, "register write");
        check({29'h0, reg_sel}, 33'h3, "write selector");
        check(33'(n_instr * 2 + n_wr), 33'h4, "cpu write strobes");
        do_cmd(CMD_REV, 32'h0, r);
        check(r, {1'b1, 16'h0000, REVISION}, "later revision reply");
        do_cmd(8'h3c, 32'h0, r);
        check(r, 33'h0, "unknown code refused");
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check({32'h0, active}, 33'h0, "debugger active after reset");
        do_cmd(CMD_REV, 32'h0, r);
        check(r, {1'b1, 16'h0000, REVISION}, "revision reply after reset");
        check({32'h0, active}, 33'h1, "debugger not active again");
        wrap_up();
    end
endmodule // debug_command_port_test
